/* File: hw/mwf_pkg.sv */
// package: constants and carriers for the multiply-working-by-file execution block
package mwf_pkg;

  // ****************************************************************
  // widths and decode constants
  // ****************************************************************
  localparam int          DATA_W          = 8;
  localparam int          PROD_W          = 16;
  localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [11:0] RESET_ADDR      = 12'h000;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef enum logic [1:0] {MWF_Q1, MWF_Q2, MWF_Q3, MWF_Q4} mwf_phase_t;

  typedef struct packed {
    logic       valid;
    logic       access_bit;
    logic [7:0] file_addr;
  } mwf_instr_t;

  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } mwf_product_t;

endpackage : mwf_pkg

/* File: hw/mwf_addr_resolve.sv */
// module: resolves the 12-bit operand address from access bit, bank select and index
`timescale 1ns/1ps
module mwf_addr_resolve
(
  // instruction fields
  input  wire logic [7:0]  file_addr,
  input  wire logic        access_bit,
  input  wire logic        ext_set_on,
  // bank and index sources
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  // resolved address
  output logic      [11:0] operand_addr
);

  always_comb
  begin
    if (!access_bit && ext_set_on && file_addr <= mwf_pkg::INDEX_LIMIT)
      operand_addr = index_base + {4'h0, file_addr};
    else if (!access_bit)
    begin
      // access bank: low half maps to bank 0, high half to the top bank
      if (file_addr < mwf_pkg::ACCESS_SPLIT)
        operand_addr = {4'h0, file_addr};
      else
        operand_addr = {mwf_pkg::ACCESS_HI_BANK, file_addr};
    end
    else
      operand_addr = {bank_select_register, file_addr};
  end

endmodule : mwf_addr_resolve

/* File: hw/mwf_exec.sv */
// module: four-quarter execution of the multiply-working-by-file instruction
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module mwf_exec
(
  // clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 CLK_EN,
  // instruction issue, sampled in Q1
  input  wire mwf_pkg::mwf_instr_t  INSTR,
  input  wire logic                 EXT_SET_ON,
  // core state
  input  wire logic [7:0]           WORKING_REG,
  input  wire logic [3:0]           BANK_SELECT_REGISTER,
  input  wire logic [11:0]          INDEX_BASE,
  // register file read port
  output logic      [11:0]          RF_READ_ADDR,
  input  wire logic [7:0]           RF_READ_DATA,
  // product register write port
  output logic                      PROD_WRITE,
  output mwf_pkg::mwf_product_t     PROD_DATA,
  // phase and status
  output mwf_pkg::mwf_phase_t       PHASE,
  output logic                      BUSY
);

  // ****************************************************************
  // state
  // ****************************************************************
  mwf_pkg::mwf_phase_t   phase_r;
  mwf_pkg::mwf_phase_t   phase_nxt;
  logic                  active_r;
  mwf_pkg::mwf_instr_t   instr_r;
  logic                  ext_r;
  logic [7:0]            operand_r;
  logic [7:0]            w_r;
  mwf_pkg::mwf_product_t product_r;
  mwf_pkg::mwf_product_t prod_out_r;
  logic                  prod_write_r;
  logic [11:0]           resolved_addr;

  // multiplier array
  mwf_pkg::mwf_product_t product_nxt;
  logic [15:0]           w_wide;
  logic [15:0]           partial   [mwf_pkg::DATA_W];
  logic [15:0]           sum_chain [mwf_pkg::DATA_W+1];

  // stage strobes, enable folded in
  logic                  q2_read;
  logic                  q3_mult;
  logic                  q4_write;

  // ****************************************************************
  // quarter sequencer
  // ****************************************************************
  always_comb
  begin
    case (phase_r)
      mwf_pkg::MWF_Q1: phase_nxt = mwf_pkg::MWF_Q2;
      mwf_pkg::MWF_Q2: phase_nxt = mwf_pkg::MWF_Q3;
      mwf_pkg::MWF_Q3: phase_nxt = mwf_pkg::MWF_Q4;
      mwf_pkg::MWF_Q4: phase_nxt = mwf_pkg::MWF_Q1;
      default:         phase_nxt = mwf_pkg::MWF_Q1;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      phase_r <= mwf_pkg::MWF_Q1;
    else if (CLK_EN)
      phase_r <= phase_nxt;
  end

  // ****************************************************************
  // stage decode
  // ****************************************************************
  // a stage belongs to an instruction only while it is busy, so a refused
  // Q1 slot reloads instr_r and ext_r but touches no operand, product or strobe state
  function automatic logic stage_on
  (
    input logic                busy,
    input mwf_pkg::mwf_phase_t now,
    input mwf_pkg::mwf_phase_t want
  );
    return busy && (now == want);
  endfunction : stage_on

  // the enable is folded in here, so nothing moves while the core is stalled
  assign q2_read  = CLK_EN && stage_on(active_r, phase_r, mwf_pkg::MWF_Q2);
  assign q3_mult  = CLK_EN && stage_on(active_r, phase_r, mwf_pkg::MWF_Q3);
  assign q4_write = CLK_EN && stage_on(active_r, phase_r, mwf_pkg::MWF_Q4);

  // ****************************************************************
  // Q1 decode: latch instruction, it occupies exactly one enabled cycle
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      instr_r <= '0;
      ext_r   <= 1'b0;
    end
    else if (CLK_EN && phase_r == mwf_pkg::MWF_Q1)
    begin
      instr_r <= INSTR;
      ext_r   <= EXT_SET_ON;
    end
  end

  // busy from the Q1 take to the close of Q4; a refused slot leaves it low
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      active_r <= 1'b0;
    else if (CLK_EN)
    begin
      if (phase_r == mwf_pkg::MWF_Q1)
        active_r <= INSTR.valid;
      else if (phase_r == mwf_pkg::MWF_Q4)
        active_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Q2 operand read
  // ****************************************************************
  mwf_addr_resolve u_resolve
  (
    .file_addr            (instr_r.file_addr),
    .access_bit           (instr_r.access_bit),
    .ext_set_on           (ext_r),
    .bank_select_register (BANK_SELECT_REGISTER),
    .index_base           (INDEX_BASE),
    .operand_addr         (resolved_addr)
  );

  assign RF_READ_ADDR = resolved_addr;

  // copies only: the working register and the file byte are never written back
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      operand_r <= mwf_pkg::RESET_BYTE;
      w_r       <= mwf_pkg::RESET_BYTE;
    end
    else if (q2_read)
    begin
      operand_r <= RF_READ_DATA;
      w_r       <= WORKING_REG;
    end
  end

  // ****************************************************************
  // Q3 multiply; no flag output exists, so zero is not reported
  // ****************************************************************
  // shift-and-add array, one partial product per operand bit; the carry chain
  // is long but has a whole clock cycle to settle
  assign w_wide       = {8'h00, w_r};
  assign sum_chain[0] = 16'h0000;

  generate
    for (genvar i = 0; i < mwf_pkg::DATA_W; i++)
    begin : g_partial
      // a set operand bit adds the working byte shifted to its weight
      assign partial[i]     = operand_r[i] ? (w_wide << i) : 16'h0000;
      assign sum_chain[i+1] = sum_chain[i] + partial[i];
    end
  endgenerate

  assign product_nxt = sum_chain[mwf_pkg::DATA_W];

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      product_r <= {mwf_pkg::RESET_BYTE, mwf_pkg::RESET_BYTE};
    else if (q3_mult)
      product_r <= product_nxt;
  end

  // ****************************************************************
  // Q4 write of the whole pair in one strobe
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      prod_write_r <= 1'b0;
    else if (CLK_EN)
      prod_write_r <= q4_write;
  end

  // both bytes move on one edge, so a reader never sees half a product
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      prod_out_r <= {mwf_pkg::RESET_BYTE, mwf_pkg::RESET_BYTE};
    else if (q4_write)
      prod_out_r <= product_r;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // strobe is registered, so the write lands on the edge closing the Q1 that follows Q4
  assign PROD_WRITE = prod_write_r && CLK_EN;
  assign PROD_DATA  = prod_out_r;
  assign PHASE      = phase_r;
  assign BUSY       = active_r;

endmodule : mwf_exec

/* File: testbench/mwf_exec_asserts.sv */
// checker: timing and data relations at the mwf_exec ports
`timescale 1ns/1ps
module mwf_exec_asserts
(
  // watched ports
  input wire logic                  CLK,
  input wire logic                  RESET_N,
  input wire logic                  CLK_EN,
  input wire mwf_pkg::mwf_instr_t   INSTR,
  input wire logic                  EXT_SET_ON,
  input wire logic [7:0]            WORKING_REG,
  input wire logic [3:0]            BANK_SELECT_REGISTER,
  input wire logic [11:0]           INDEX_BASE,
  input wire logic [11:0]           RF_READ_ADDR,
  input wire logic [7:0]            RF_READ_DATA,
  input wire logic                  PROD_WRITE,
  input wire mwf_pkg::mwf_product_t PROD_DATA,
  input wire mwf_pkg::mwf_phase_t   PHASE,
  input wire logic                  BUSY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_take;
    CLK_EN && PHASE == mwf_pkg::MWF_Q1 && INSTR.valid;
  endsequence
  // stalls stretch the frame, so only fully enabled frames pin the latency
  sequence s_frame;
    s_take ##1 CLK_EN [*4];
  endsequence
  sequence s_skip;
    CLK_EN && PHASE == mwf_pkg::MWF_Q1 && !INSTR.valid;
  endsequence
  sequence s_idx;
    s_take ##0 (!INSTR.access_bit && EXT_SET_ON && INSTR.file_addr <= 8'h5F);
  endsequence
  sequence s_acc;
    s_take ##0 (!INSTR.access_bit && !(EXT_SET_ON && INSTR.file_addr <= 8'h5F));
  endsequence
  a_write_lat: assert property (s_frame |-> PROD_WRITE)
    else $error("product strobe late");
  a_prod_val: assert property (s_frame |->
    PROD_DATA == $past(WORKING_REG, 3) * $past(RF_READ_DATA, 3)) else $error("bad product");
  a_write_q1: assert property (PROD_WRITE |-> PHASE == mwf_pkg::MWF_Q1)
    else $error("strobe outside Q1");
  a_data_hold: assert property ($changed(PROD_DATA) |-> $past(PHASE) == mwf_pkg::MWF_Q4)
    else $error("product moved off Q4");
  a_phase_step: assert property (CLK_EN |=>
    PHASE == mwf_pkg::mwf_phase_t'($past(PHASE) + 2'h1)) else $error("phase skipped");
  a_bank_addr: assert property (s_take ##0 INSTR.access_bit |=>
    RF_READ_ADDR == {BANK_SELECT_REGISTER, $past(INSTR.file_addr)}) else $error("bank address");
  a_index_addr: assert property (s_idx |=>
    RF_READ_ADDR == INDEX_BASE + $past(INSTR.file_addr)) else $error("index address");
  a_access_bank: assert property (s_acc |=>
    RF_READ_ADDR == {{4{$past(INSTR.file_addr[7])}}, $past(INSTR.file_addr)}) else $error("access");
  a_busy_take: assert property (s_take |=> BUSY)
    else $error("busy not raised");
  a_busy_idle: assert property (PHASE == mwf_pkg::MWF_Q1 |-> !BUSY)
    else $error("busy in Q1");
  a_busy_refuse: assert property (s_skip |=> !BUSY)
    else $error("refused slot busy");
  a_no_write: assert property (s_skip ##1 CLK_EN [*4] |-> !PROD_WRITE)
    else $error("refused slot wrote");
endmodule : mwf_exec_asserts
bind mwf_exec mwf_exec_asserts chk_u (.*);

/* File: testbench/mwf_exec_tb.sv */
// testbench: random multiply frames against a register file stand-in
`timescale 1ns/1ps
module mwf_exec_tb;
  logic                  clk = 1'b0, reset_n = 1'b0, clk_en = 1'b0, ext_on = 1'b0;
  mwf_pkg::mwf_instr_t   instr = '0;
  logic [7:0]            w_reg = 8'h00, f;
  logic [3:0]            bank_sel = 4'h0;
  logic [11:0]           ibase = 12'h000, rd_addr;
  logic                  pwr;
  mwf_pkg::mwf_product_t pdata;
  mwf_pkg::mwf_phase_t   phase;
  logic [15:0]           exp_q[$];
  int                    fails = 0, check_count = 0, cyc = 0;
  // byte mixes bank and offset bits, so a wrong bank or a wrong offset alone shows as a wrong product for nonzero W
  function automatic logic [7:0] rf(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
  endfunction : rf
  function automatic logic [11:0] ea(input logic a, input logic x, input logic [7:0] v);
    if (a) return {bank_sel, v};
    if (x && v <= 8'h5F) return ibase + v;
    return {{4{v[7]}}, v};
  endfunction : ea
  mwf_exec dut_u (.CLK(clk), .RESET_N(reset_n), .CLK_EN(clk_en), .INSTR(instr),
    .EXT_SET_ON(ext_on), .WORKING_REG(w_reg), .BANK_SELECT_REGISTER(bank_sel),
    .INDEX_BASE(ibase), .RF_READ_ADDR(rd_addr), .RF_READ_DATA(rf(rd_addr)),
    .PROD_WRITE(pwr), .PROD_DATA(pdata), .PHASE(phase), .BUSY());
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial
  begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (reset_n && pwr === 1'b1)
      chk(exp_q.size() ? exp_q.pop_front() : 16'hXXXX, pdata);
    if (cyc == 4000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(62032));
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (300)
    begin
      f = ($urandom % 2) ? 8'($urandom) : 8'h5E + 8'($urandom % 3);
      instr = {($urandom % 4 != 0), 1'($urandom), f};
      ext_on = 1'($urandom);
      bank_sel = 4'($urandom);
      ibase = 12'($urandom);
      w_reg = 8'($urandom);
      clk_en = 1'b1;
      if (instr.valid) exp_q.push_back({8'h00, w_reg} * rf(ea(instr.access_bit, ext_on, f)));
      do
      begin
        @(negedge clk);
        if (phase !== mwf_pkg::MWF_Q1)
        begin
          clk_en = ($urandom % 4 != 0);
          // a request outside Q1 must be ignored
          instr = 10'($urandom);
        end
      end while (phase !== mwf_pkg::MWF_Q1);
    end
    instr.valid = 1'b0;
    clk_en = 1'b1;
    repeat (6) @(negedge clk);
    chk(16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule : mwf_exec_tb
